// >>> sim/epv_core_model.sv
// Core model that enters offered vectors and returns them later.
module epv_core_model #(
    parameter int HOLD = 20
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic take_req,
    input wire logic [epv_pkg::VEC_W-1:0] take_vec,
    output logic entry_ack,
    output logic exc_return,
    output logic [epv_pkg::VEC_W-1:0] return_vec
);
    timeunit 1ns;
    timeprecision 1ns;
    import epv_pkg::*;
    logic [VEC_W-1:0] stack[$];
    logic [ADDR_W-1:0] table_img [NUM_VEC];
    int gap = 0;
    initial {entry_ack, exc_return, return_vec} = '0;
    // Software's table image: each handler word carries its vector in
    // bits 13:8 and has bit 0 set to mark compact code.
    initial begin
        for (int k = 0; k < NUM_VEC; k++) begin
            table_img[k] = (ADDR_W'(k) << 8) | 32'h1;
        end
    end
    // Handlers nest, so the newest entry returns first.
    always @(posedge clk) begin
        entry_ack <= 1'b0;
        exc_return <= 1'b0;
        return_vec <= ~return_vec;
        gap <= gap + 1;
        if (!nrst) begin
            stack.delete();
            gap <= 0;
        end else begin
            if (entry_ack && take_req) begin
                // The fetched handler word names the vector to return.
                stack.push_back(table_img[take_vec][8 +: VEC_W]);
            end
            // A short gap hides an offer still computed from old state.
            if (take_req && !entry_ack && gap >= 3) begin
                entry_ack <= 1'b1;
                gap <= 0;
            end else if (!take_req && stack.size() > 0 && gap >= HOLD) begin
                exc_return <= 1'b1;
                return_vec <= stack.pop_back();
                gap <= 0;
            end
        end
    end
endmodule

// >>> sim/test_exception_priority_vectoring.sv
// Testbench for the exception arbiter facing a core model.
module test_exception_priority_vectoring;
    timeunit 1ns;
    timeprecision 1ns;
    import epv_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [NUM_VEC-1:0] exc_req = '0;
    logic vbase_wr = 1'b0;
    logic vbase_priv = 1'b0;
    logic [ADDR_W-1:0] vbase_wdata = '0;
    logic prio_wr = 1'b0;
    logic [VEC_W-1:0] prio_idx = '0;
    logic [PRIO_W-1:0] prio_wdata = '0;
    logic entry_ack, exc_return, take_req;
    logic [VEC_W-1:0] return_vec, take_vec;
    logic [ADDR_W-1:0] take_addr, sp_addr, vector_table_base, base;
    logic signed [SPRIO_W-1:0] take_prio, run_prio;
    logic [NUM_VEC-1:0] pend_state, act_state;
    logic [VEC_W+ADDR_W-1:0] exp_q[$];
    logic [VEC_W+ADDR_W-1:0] exp_w;
    int err_total = 0;
    int n_compared = 0;
    int seed = 32'h26e4;
    int i, v;
    always #25 clk = ~clk;
    epv_arbiter i_epv_arbiter (.clk(clk), .nrst(nrst), .exc_req(exc_req),
        .vbase_wr(vbase_wr), .vbase_priv(vbase_priv),
        .vbase_wdata(vbase_wdata), .prio_wr(prio_wr), .prio_idx(prio_idx),
        .prio_wdata(prio_wdata), .entry_ack(entry_ack),
        .exc_return(exc_return), .return_vec(return_vec),
        .take_req(take_req), .take_vec(take_vec), .take_addr(take_addr),
        .take_prio(take_prio), .sp_addr(sp_addr),
        .vector_table_base(vector_table_base), .run_prio(run_prio),
        .pend_state(pend_state), .act_state(act_state));
    epv_core_model i_epv_core_model (.clk(clk), .nrst(nrst),
        .take_req(take_req), .take_vec(take_vec), .entry_ack(entry_ack),
        .exc_return(exc_return), .return_vec(return_vec));
    task automatic stop_test;
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic expect_entry(input int vec);
        exp_q.push_back({VEC_W'(vec), base + ADDR_W'(vec * 4)});
    endtask
    task automatic fire(input logic [NUM_VEC-1:0] m);
        @(posedge clk) exc_req <= m;
        @(posedge clk) exc_req <= '0;
    endtask
    task automatic set_prio(input int idx, input int p);
        @(posedge clk) {prio_wr, prio_idx, prio_wdata} <= {1'b1,
            VEC_W'(idx), PRIO_W'(p)};
        @(posedge clk) prio_wr <= 1'b0;
    endtask
    task automatic write_base(input logic priv, input logic [31:0] d);
        @(posedge clk) {vbase_wr, vbase_priv, vbase_wdata} <= {1'b1, priv, d};
        @(posedge clk) vbase_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic settle;
        logic idle;
        for (int k = 0; k < 2000 && (exp_q.size() != 0 ||
            act_state !== '0 || pend_state !== '0); k++) @(posedge clk);
        idle = exp_q.size() == 0 && act_state === '0 && pend_state === '0;
        check(idle, "not idle");
    endtask
    // Each entry taken by the core is matched against the oldest note.
    always @(posedge clk) begin
        if (nrst && entry_ack && take_req) begin
            if (exp_q.size() == 0) begin
                check(1'b0, "unexpected entry");
            end else begin
                exp_w = exp_q.pop_front();
                check({take_vec, take_addr} === exp_w, "entry");
            end
        end
    end
    initial begin
        #(50 * 20000);
        err_total++;
        stop_test();
    end
    initial begin
        base = VBASE_RESET;
        expect_entry(VEC_RESET);
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        check(vector_table_base === 32'h0 && sp_addr === 32'h0, "base");
        settle();
        expect_entry(20);
        expect_entry(21);
        fire(64'h3 << 20);
        repeat (8) @(posedge clk);
        check(pend_state[21] === 1'b1 && act_state[21] === 1'b0, "pd");
        settle();
        write_base(1'b0, 32'h0000_0400);
        write_base(1'b1, 32'h4000_0000);
        write_base(1'b1, 32'h0000_00ff);
        check(vector_table_base === 32'h0, "bad base taken");
        write_base(1'b1, 32'h3fff_ff00);
        check(vector_table_base === 32'h3fff_ff00, "top");
        write_base(1'b1, 32'h1234_5600);
        base = 32'h1234_5600;
        check(vector_table_base === base && sp_addr === base, "rb");
        set_prio(16, 5);
        set_prio(17, 2);
        expect_entry(17);
        expect_entry(16);
        fire(64'h3 << 16);
        settle();
        set_prio(VEC_NMI, 7);
        set_prio(30, 4);
        expect_entry(30);
        fire(64'h1 << 30);
        repeat (6) @(posedge clk);
        expect_entry(VEC_NMI);
        expect_entry(VEC_BUS);
        fire((64'h1 << VEC_NMI) | (64'h1 << VEC_BUS));
        settle();
        for (i = 0; i < 8; i++) begin
            v = 16 + ($unsigned($random(seed)) % 48);
            set_prio(v, $random(seed) & 7);
            expect_entry(v);
            fire(64'h1 << v);
            settle();
        end
        stop_test();
    end
endmodule

// >>> src/epv_arbiter.sv
// Exception priority arbiter with vector address generation.
// Functional notes
// - Table base is address zero after reset until relocated.
// - Entry zero gives stack pointer reset value; others give handler starts.
// - Privileged writes relocate the table base within 0x100 to 0x3fffff00.
// - Handler offset is four times the vector number.
// - Peripheral interrupts start at vector 16, offset 0x40.
// - Lower priority value means more urgent.
// - Reset, hard fault and NMI priorities are fixed; others configurable.
// - Configurable priorities reset to zero and hold until written.
// - Configurable priorities span 0 through 7 only.
// - Fixed negative priorities always beat configurable ones.
// - Equal priorities resolve to the lowest exception number.
// - Strictly more urgent arrivals preempt the running handler.
// - Equal priority arrivals do not preempt; they stay pending.
// - Reset is -3, NMI -2, hard fault -1.
// - Each exception is inactive, pending, active, or active and pending.
module epv_arbiter (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Exception requests, one pulse or level per vector number
    input wire logic [epv_pkg::NUM_VEC-1:0] exc_req,
    // Table relocation write
    input wire logic vbase_wr,
    input wire logic vbase_priv,
    input wire logic [epv_pkg::ADDR_W-1:0] vbase_wdata,
    // Priority write
    input wire logic prio_wr,
    input wire logic [epv_pkg::VEC_W-1:0] prio_idx,
    input wire logic [epv_pkg::PRIO_W-1:0] prio_wdata,
    // Core handshake
    input wire logic entry_ack,
    input wire logic exc_return,
    input wire logic [epv_pkg::VEC_W-1:0] return_vec,
    // Outputs to the core
    output logic take_req,
    output logic [epv_pkg::VEC_W-1:0] take_vec,
    output logic [epv_pkg::ADDR_W-1:0] take_addr,
    output logic signed [epv_pkg::SPRIO_W-1:0] take_prio,
    output logic [epv_pkg::ADDR_W-1:0] sp_addr,
    output logic [epv_pkg::ADDR_W-1:0] vector_table_base,
    output logic signed [epv_pkg::SPRIO_W-1:0] run_prio,
    output logic [epv_pkg::NUM_VEC-1:0] pend_state,
    output logic [epv_pkg::NUM_VEC-1:0] act_state
);
    import epv_pkg::*;

    logic [ADDR_W-1:0] vector_table_base_reg, vector_table_base_next;
    logic [PRIO_W-1:0] prio_reg [NUM_VEC];
    logic [PRIO_W-1:0] prio_next [NUM_VEC];
    logic [NUM_VEC-1:0] pend_reg, pend_next;
    logic [NUM_VEC-1:0] act_reg, act_next;
    logic take_req_reg, take_req_next;
    logic [VEC_W-1:0] take_vec_reg, take_vec_next;
    logic [ADDR_W-1:0] take_addr_reg, take_addr_next;
    logic signed [SPRIO_W-1:0] take_prio_reg, take_prio_next;
    logic signed [SPRIO_W-1:0] run_prio_reg, run_prio_next;
    logic signed [SPRIO_W-1:0] best_prio;
    logic [VEC_W-1:0] best_vec;
    logic best_found;

    // Fixed levels are negative so they sort ahead of every stored value.
    function automatic logic signed [SPRIO_W-1:0] eff_prio(
        input logic [VEC_W-1:0] v, input logic [PRIO_W-1:0] p);
        logic signed [SPRIO_W-1:0] r;
        r = $signed({2'b00, p});
        if (v == VEC_RESET) begin
            r = PRIO_RESET_LVL;
        end else if (v == VEC_NMI) begin
            r = PRIO_NMI_LVL;
        end else if (v == VEC_HARD) begin
            r = PRIO_HARD_LVL;
        end
        return r;
    endfunction

    always_comb begin
        vector_table_base_next = vector_table_base_reg;
        // Out-of-range or unprivileged writes are dropped so that a stray
        // write cannot point the core at an unmapped table.
        if (vbase_wr && vbase_priv && vbase_wdata >= VBASE_MIN &&
            vbase_wdata <= VBASE_MAX) begin
            vector_table_base_next = vbase_wdata & VBASE_ALIGN_MASK;
        end
        for (int i = 0; i < NUM_VEC; i++) begin
            prio_next[i] = prio_reg[i];
        end
        if (prio_wr && prio_idx > VEC_HARD) begin
            prio_next[prio_idx] = prio_wdata;
        end
        best_found = 1'b0;
        best_prio = PRIO_THREAD_LVL;
        best_vec = VEC_SP;
        run_prio_next = PRIO_THREAD_LVL;
        for (int i = 1; i < NUM_VEC; i++) begin
            // Strict compare in ascending order keeps the lowest number.
            if (pend_reg[i] && !act_reg[i] &&
                eff_prio(VEC_W'(i), prio_reg[i]) < best_prio) begin
                best_found = 1'b1;
                best_prio = eff_prio(VEC_W'(i), prio_reg[i]);
                best_vec = VEC_W'(i);
            end
            if (act_reg[i] && eff_prio(VEC_W'(i), prio_reg[i]) <
                run_prio_next) begin
                run_prio_next = eff_prio(VEC_W'(i), prio_reg[i]);
            end
        end
        // Equal level never wins, whatever the number. The level is taken
        // from the active set as it stands now, and nothing is offered in
        // an entry cycle, so a stale winner never reaches the core.
        take_req_next = best_found && (best_prio < run_prio_next) &&
            !(entry_ack && take_req_reg);
        take_vec_next = best_vec;
        take_prio_next = best_prio;
        take_addr_next = vector_table_base_reg +
            {{(ADDR_W-VEC_W-2){1'b0}}, best_vec, 2'b00};
        act_next = act_reg;
        pend_next = pend_reg;
        if (exc_return) begin
            act_next[return_vec] = 1'b0;
        end
        if (entry_ack && take_req_reg) begin
            act_next[take_vec_reg] = 1'b1;
            pend_next[take_vec_reg] = 1'b0;
        end
        // A request in the clearing cycle is kept pending.
        pend_next = pend_next | (exc_req & VEC_VALID);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            vector_table_base_reg <= VBASE_RESET;
            for (int i = 0; i < NUM_VEC; i++) begin
                prio_reg[i] <= PRIO_CFG_RESET;
            end
            pend_reg <= PEND_RESET;
            act_reg <= '0;
            take_req_reg <= 1'b0;
            take_vec_reg <= VEC_SP;
            take_addr_reg <= VBASE_RESET;
            take_prio_reg <= PRIO_THREAD_LVL;
            run_prio_reg <= PRIO_THREAD_LVL;
        end else begin
            vector_table_base_reg <= vector_table_base_next;
            prio_reg <= prio_next;
            pend_reg <= pend_next;
            act_reg <= act_next;
            take_req_reg <= take_req_next;
            take_vec_reg <= take_vec_next;
            take_addr_reg <= take_addr_next;
            take_prio_reg <= take_prio_next;
            run_prio_reg <= run_prio_next;
        end
    end

    assign take_req = take_req_reg;
    assign take_vec = take_vec_reg;
    assign take_addr = take_addr_reg;
    assign take_prio = take_prio_reg;
    assign sp_addr = vector_table_base_reg;
    assign vector_table_base = vector_table_base_reg;
    assign run_prio = run_prio_reg;
    assign pend_state = pend_reg;
    assign act_state = act_reg;

    AST_BASE_RESET: assert property (@(posedge clk)
        !nrst |=> vector_table_base_reg == VBASE_RESET)
        else $error("table base not zero after reset");
    AST_SP_ENTRY: assert property (@(posedge clk) disable iff (!nrst)
        sp_addr == vector_table_base_reg)
        else $error("stack pointer entry not at table base");
    AST_RELOCATE: assert property (@(posedge clk) disable iff (!nrst)
        vbase_wr && vbase_priv && vbase_wdata == VBASE_MIN
        |=> vector_table_base_reg == VBASE_MIN)
        else $error("relocation write not taken");
    AST_NO_UNPRIV: assert property (@(posedge clk) disable iff (!nrst)
        vbase_wr && !vbase_priv |=> $stable(vector_table_base_reg))
        else $error("unprivileged write moved table base");
    AST_OFFSET: assert property (@(posedge clk) disable iff (!nrst)
        take_req_reg && $past(nrst) |-> take_addr_reg ==
        $past(vector_table_base_reg) +
        {{(ADDR_W-VEC_W-2){1'b0}}, take_vec_reg, 2'b00})
        else $error("handler address is not base plus four times vector");
    AST_IRQ_BASE: assert property (@(posedge clk) disable iff (!nrst)
        take_req_reg && take_vec_reg >= VEC_IRQ0 |->
        take_addr_reg - $past(vector_table_base_reg) >= IRQ_OFFSET)
        else $error("interrupt vector below offset 0x40");
    AST_PRIO_RESET: assert property (@(posedge clk)
        !nrst |=> prio_reg[VEC_BUS] == PRIO_CFG_RESET)
        else $error("configurable priority not zero after reset");
    AST_FIXED_PRIO: assert property (@(posedge clk) disable iff (!nrst)
        take_req_reg && take_vec_reg == VEC_NMI |->
        take_prio_reg == PRIO_NMI_LVL)
        else $error("fixed priority was changed");
    AST_FIXED_WINS: assert property (@(posedge clk) disable iff (!nrst)
        take_req_reg && take_vec_reg > VEC_HARD |->
        ($past(pend_reg[3:1] & ~act_reg[3:1]) == 3'h0))
        else $error("configurable exception beat a fixed one");
    AST_STRICT: assert property (@(posedge clk) disable iff (!nrst)
        take_req_reg |-> take_prio_reg < run_prio_reg)
        else $error("preemption without strictly higher priority");
    AST_PEND_SET: assert property (@(posedge clk) disable iff (!nrst)
        exc_req[VEC_BUS] |=> pend_reg[VEC_BUS])
        else $error("request did not set pending");
    AST_NMI_PREEMPT: assert property (@(posedge clk) disable iff (!nrst)
        pend_reg[VEC_NMI] && !act_reg[VEC_NMI] && !act_reg[VEC_RESET] &&
        !(entry_ack && take_req_reg) |=>
        take_req_reg && take_prio_reg <= PRIO_NMI_LVL)
        else $error("pending NMI did not preempt");
    AST_NO_SP_OFFER: assert property (@(posedge clk) disable iff (!nrst)
        take_req_reg |-> take_vec_reg != VEC_SP)
        else $error("stack pointer entry offered as a handler");
    AST_NO_REOFFER: assert property (@(posedge clk) disable iff (!nrst)
        take_req_reg |-> !act_reg[take_vec_reg])
        else $error("active vector offered again");
    AST_PRIO_RANGE: assert property (@(posedge clk) disable iff (!nrst)
        take_req_reg && take_vec_reg > VEC_HARD |->
        take_prio_reg >= 5'sd0 && take_prio_reg <= 5'sd7)
        else $error("configurable priority outside 0 to 7");
endmodule

// >>> src/epv_pkg.sv
// Package of constants for exception priority arbitration and vectoring.
package epv_pkg;
    localparam int NUM_VEC = 64;
    localparam int VEC_W = 6;
    localparam int PRIO_W = 3;
    localparam int SPRIO_W = 5;
    localparam int ADDR_W = 32;
    localparam logic [ADDR_W-1:0] VBASE_RESET = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] VBASE_MIN = 32'h0000_0100;
    localparam logic [ADDR_W-1:0] VBASE_MAX = 32'h3fff_ff00;
    localparam logic [ADDR_W-1:0] VBASE_ALIGN_MASK = 32'hffff_ff00;
    localparam logic [ADDR_W-1:0] IRQ_OFFSET = 32'h0000_0040;
    localparam logic [VEC_W-1:0] VEC_SP = 6'h00;
    localparam logic [VEC_W-1:0] VEC_RESET = 6'h01;
    localparam logic [VEC_W-1:0] VEC_NMI = 6'h02;
    localparam logic [VEC_W-1:0] VEC_HARD = 6'h03;
    localparam logic [VEC_W-1:0] VEC_BUS = 6'h05;
    localparam logic [VEC_W-1:0] VEC_IRQ0 = 6'h10;
    localparam logic signed [SPRIO_W-1:0] PRIO_RESET_LVL = -5'sd3;
    localparam logic signed [SPRIO_W-1:0] PRIO_NMI_LVL = -5'sd2;
    localparam logic signed [SPRIO_W-1:0] PRIO_HARD_LVL = -5'sd1;
    localparam logic signed [SPRIO_W-1:0] PRIO_THREAD_LVL = 5'sd8;
    localparam logic [PRIO_W-1:0] PRIO_CFG_RESET = 3'h0;
    localparam logic [NUM_VEC-1:0] VEC_VALID = 64'hffff_ffff_ffff_d87e;
    localparam logic [NUM_VEC-1:0] PEND_RESET = 64'h0000_0000_0000_0002;
endpackage
